// >>> inc/ipseq_if.sv
// Interface joining the sequencer device and its trigger partner.
interface ipseq_if;
    logic frameSyncOut;      // Frame or pattern-set trigger from the device.
    logic exposureStrobeOut; // Exposure strobe from the device.
    logic patternReady;      // Device can accept a trigger.
    logic patternAdvanceIn;  // Trigger from the partner.

    // Device end.
    modport device (output frameSyncOut, output exposureStrobeOut, output patternReady, input patternAdvanceIn);
    // Partner end.
    modport partner (input frameSyncOut, input exposureStrobeOut, input patternReady, output patternAdvanceIn);
endinterface

// >>> inc/ipseq_pkg.sv
// Package with the shared constants and types of the internal pattern sequencer.
package ipseq_pkg;
    // ------------------------------------------------------------------
    // Register offsets of the device's own command port.
    // ------------------------------------------------------------------
    localparam logic [3:0] IPSEQ_REG_CTRL     = 4'h0; // Mode, start, polarity, orientation.
    localparam logic [3:0] IPSEQ_REG_PREDARK  = 4'h1; // Pre-exposure dark time in cycles.
    localparam logic [3:0] IPSEQ_REG_EXPOSE   = 4'h2; // Exposure time in cycles.
    localparam logic [3:0] IPSEQ_REG_POSTDARK = 4'h3; // Post-exposure dark time in cycles.
    localparam logic [3:0] IPSEQ_REG_FSDELAY  = 4'h4; // Frame sync delay in cycles.
    localparam logic [3:0] IPSEQ_REG_ESDELAY  = 4'h5; // Exposure strobe delay in cycles.
    localparam logic [3:0] IPSEQ_REG_SETLEN   = 4'h6; // Last pattern index of the set and frame period.
    localparam logic [3:0] IPSEQ_REG_STATUS   = 4'h7; // Running, loaded, ready, pattern index.
    localparam logic [3:0] IPSEQ_REG_PATWR    = 4'h8; // Flash load: index and row data.

    // ------------------------------------------------------------------
    // Control register fields.
    // ------------------------------------------------------------------
    localparam int IPSEQ_CTRL_ENABLE  = 0; // Internal pattern display selected.
    localparam int IPSEQ_CTRL_TRIGIN  = 1; // One is trigger-in, zero is free-running.
    localparam int IPSEQ_CTRL_FSPOL   = 2; // One gives active-high frame sync.
    localparam int IPSEQ_CTRL_ESPOL   = 3; // One gives active-high exposure strobe.
    localparam int IPSEQ_CTRL_COLREP  = 4; // One replicates along columns.
    localparam int IPSEQ_CTRL_START   = 5; // Write one to load and start display.
    localparam logic [7:0] IPSEQ_CTRL_RESET = 8'h0C;

    // ------------------------------------------------------------------
    // Widths and sizes.
    // ------------------------------------------------------------------
    localparam int IPSEQ_DW    = 32; // Register data width.
    localparam int IPSEQ_TW    = 24; // Timer width.
    localparam int IPSEQ_PW    = 16; // One-dimensional pattern width.
    localparam int IPSEQ_DEPTH = 8;  // Patterns held in internal memory.
    localparam int IPSEQ_IW    = 3;  // Pattern index width.

    // ------------------------------------------------------------------
    // Timing.
    // ------------------------------------------------------------------
    localparam int IPSEQ_CLK_MHZ     = 100; // Clock rate.
    localparam int IPSEQ_FS_PULSE_US = 20;  // Least frame sync pulse width.
    localparam logic [IPSEQ_TW-1:0] IPSEQ_FS_PULSE_CYC = IPSEQ_TW'(IPSEQ_FS_PULSE_US * IPSEQ_CLK_MHZ);
    localparam logic [IPSEQ_TW-1:0] IPSEQ_TIME_RESET   = 24'h000010;

    // Pattern phase states.
    typedef enum logic [2:0] {
        IPSEQ_IDLE,
        IPSEQ_LOAD,
        IPSEQ_WAIT,
        IPSEQ_PRE,
        IPSEQ_EXP,
        IPSEQ_POST,
        IPSEQ_FILL
    } ipseq_state_t;
endpackage

// >>> tb/ipseq_chk.sv
// Concurrent checks on the trigger link between the sequencer and its partner.
module ipseq_chk
    import ipseq_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Link signals.
    input wire logic frameSyncOut,
    input wire logic exposureStrobeOut,
    input wire logic patternReady,
    input wire logic patternAdvanceIn
);
    logic [IPSEQ_TW-1:0] fsRun; // Cycles the frame sync has stood high.

    // ------------------------------------------------------------------
    // Pulse length counter.
    // ------------------------------------------------------------------
    // Restarts whenever the frame sync is low.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            fsRun <= '0;
        else
            fsRun <= frameSyncOut ? fsRun + 1'h1 : '0;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // ------------------------------------------------------------------
    // Link assertions.
    // ------------------------------------------------------------------
    chk_ready_drops: assert property (patternReady && patternAdvanceIn |=> !patternReady)
        else $error("ready stayed high after a trigger");
    chk_ready_low: assert property ($fell(patternReady) |-> !patternReady [*3])
        else $error("ready came back too soon");
    chk_adv_pulse: assert property (patternAdvanceIn |=> !patternAdvanceIn)
        else $error("advance pulse longer than one cycle");
    chk_adv_ready: assert property (patternAdvanceIn |-> patternReady)
        else $error("advance sent while not ready");
    chk_strobe_dark: assert property (exposureStrobeOut |-> !patternReady)
        else $error("ready high during exposure strobe");
    chk_strobe_len: assert property ($rose(exposureStrobeOut) |-> ##[1:64] !exposureStrobeOut)
        else $error("exposure strobe did not end");
    chk_fs_width: assert property ($fell(frameSyncOut) |-> fsRun == IPSEQ_FS_PULSE_CYC)
        else $error("frame sync pulse width wrong");
    chk_ready_fresh: assert property ($rose(patternReady) |-> !exposureStrobeOut && !patternAdvanceIn)
        else $error("ready rose before the pattern ended");
endmodule

// >>> tb/test_internal_pattern_sequencer.sv
// Self-checking bench for the sequencer device and its trigger partner.
module test_internal_pattern_sequencer
    import ipseq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic                clk, resetn, regWrite, regRead, fireReq, fireTaken;
    logic                mirrorColumns, illumOn, checkLine;
    logic [3:0]          regAddr;
    logic [IPSEQ_DW-1:0] regWdata, regRdata;
    logic [IPSEQ_PW-1:0] mirrorLine, expLine;
    logic [15:0]         frameCount, exposureCount;
    int                  n_mismatch, check_count, expCycles, e0, f0, expo, pats[8];
    ipseq_if             link();

    ipseq_device i_ipseq_device (.clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .link(link.device),
        .mirrorLine(mirrorLine), .mirrorColumns(mirrorColumns), .illumOn(illumOn));
    ipseq_partner i_ipseq_partner (.clk(clk), .resetn(resetn), .link(link.partner), .fireReq(fireReq),
        .fireTaken(fireTaken), .frameCount(frameCount), .exposureCount(exposureCount));
    ipseq_chk i_ipseq_chk (.clk(clk), .resetn(resetn), .frameSyncOut(link.frameSyncOut),
        .exposureStrobeOut(link.exposureStrobeOut), .patternReady(link.patternReady),
        .patternAdvanceIn(link.patternAdvanceIn));

    // ------------------------------------------------------------------
    // Helpers.
    // ------------------------------------------------------------------
    // Counts a comparison and reports a mismatch.
    task automatic check(input string what, input logic [31:0] expv, input logic [31:0] got);
        check_count++;
        if (got !== expv) begin
            n_mismatch++;
            $display("ERROR %s expected %0h seen %0h", what, expv, got);
        end
    endtask
    // One-cycle register write.
    task automatic regWr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'h1;
        @(posedge clk);
        regWrite <= 1'h0;
    endtask
    // One-cycle read; the data is taken in the following cycle.
    task automatic regChk(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'h1;
        @(posedge clk);
        regRead <= 1'h0;
        #1 check("regRdata", e, regRdata);
    endtask
    // Holds the request until the edge at which the partner takes it, so only one trigger is sent.
    task automatic fire();
        @(posedge clk);
        fireReq <= 1'h1;
        for (int i = 0; i < 2000; i++) begin
            @(posedge clk);
            if (fireTaken === 1'h1) break;
        end
        fireReq <= 1'h0;
    endtask
    // Waits, bounded, for the next frame sync edge.
    task automatic waitFrame();
        f0 = frameCount;
        for (int i = 0; i < 4000 && frameCount == 16'(f0); i++) @(negedge clk);
    endtask
    // Prints the verdict and ends the run.
    task automatic test_done();
        if (n_mismatch == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Free-running clock, 100 MHz.
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    // Watchdog: far beyond the expected run length.
    initial begin
        #400us;
        n_mismatch++;
        test_done();
    end
    // Counts lit cycles and, while checkLine is set, checks the line shown in each.
    always @(negedge clk) begin
        if (illumOn === 1'h1) begin
            expCycles++;
            if (checkLine) check("mirrorLine", expLine, mirrorLine);
        end else if (resetn) begin
            check("dark mirrorLine", 16'h0, mirrorLine);
        end
    end

    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial begin
        resetn = 1'h0;
        {regAddr, regWdata, regWrite, regRead, fireReq} = '0;
        checkLine = 1'h1;
        void'($urandom(55826));
        repeat (16) @(posedge clk);
        resetn <= 1'h1;
        regChk(IPSEQ_REG_CTRL, {24'h0, IPSEQ_CTRL_RESET});
        regChk(4'hF, 32'h0);
        regChk(IPSEQ_REG_STATUS, 32'h0);
        // Preload the pattern store with random lines.
        for (int i = 0; i < 8; i++) begin
            pats[i] = $urandom_range(16'hFFFF, 0);
            regWr(IPSEQ_REG_PATWR, {13'h0, 3'(i), pats[i][15:0]});
        end
        regChk(IPSEQ_REG_PATWR, 32'h0);
        // The strobe needs its delay plus two cycles, so shorter exposures would show no strobe.
        expo = $urandom_range(12, 4);
        regWr(IPSEQ_REG_PREDARK, 32'h3);
        regWr(IPSEQ_REG_EXPOSE, 32'(expo));
        regWr(IPSEQ_REG_POSTDARK, 32'h2);
        regWr(IPSEQ_REG_FSDELAY, 32'h4);
        regWr(IPSEQ_REG_ESDELAY, 32'h1);
        regWr(IPSEQ_REG_SETLEN, 32'h02000BB8);
        regChk(IPSEQ_REG_EXPOSE, 32'(expo));
        // Trigger mode: three patterns, one set.
        regWr(IPSEQ_REG_CTRL, 32'h2F);
        for (int i = 0; i < 200 && link.patternReady !== 1'h1; i++) @(negedge clk);
        check("patternReady", 1'h1, link.patternReady);
        f0 = frameCount;
        for (int k = 0; k < 3; k++) begin
            expLine = pats[k][15:0];
            expCycles = 0;
            e0 = exposureCount;
            fire();
            repeat (3) @(negedge clk);
            for (int i = 0; i < 200 && link.patternReady !== 1'h1; i++) @(negedge clk);
            check("exposure cycles", expo, expCycles);
            check("strobe count", e0 + 1, exposureCount);
        end
        repeat (2100) @(negedge clk);
        check("set triggers", f0 + 1, frameCount);
        check("mirrorColumns", 1'h0, mirrorColumns);
        // Free-running mode with column replication.
        regWr(IPSEQ_REG_CTRL, 32'h0C);
        regWr(IPSEQ_REG_CTRL, 32'h3D);
        checkLine = 1'h0;
        waitFrame();
        e0 = exposureCount;
        expCycles = 0;
        check("ready in free run", 1'h0, link.patternReady);
        waitFrame();
        check("strobes per set", 3, exposureCount - e0);
        check("lit cycles per set", 3 * expo, expCycles);
        check("mirrorColumns", 1'h1, mirrorColumns);
        test_done();
    end
endmodule

// >>> verilog/ipseq_device.sv
// Internal pattern sequencer: device end with command port and trigger link.
//
// Chosen here: the register addresses and the strobed register port.
module ipseq_device
    import ipseq_pkg::*;
(
    // Clock and reset.
    input  wire logic                 clk,
    input  wire logic                 resetn,
    // Command port.
    input  wire logic [3:0]           regAddr,
    input  wire logic [IPSEQ_DW-1:0]  regWdata,
    input  wire logic                 regWrite,
    input  wire logic                 regRead,
    output logic      [IPSEQ_DW-1:0]  regRdata,
    // Link to the partner.
    ipseq_if.device                   link,
    // Mirror array and illumination.
    output logic      [IPSEQ_PW-1:0]  mirrorLine,
    output logic                      mirrorColumns,
    output logic                      illumOn
);
    // ------------------------------------------------------------------
    // Registers.
    // ------------------------------------------------------------------
    logic [7:0]          ctrl_reg;                 // Control bits.
    logic [IPSEQ_TW-1:0] preDark_reg;              // Pre-dark duration.
    logic [IPSEQ_TW-1:0] expose_reg;               // Exposure duration.
    logic [IPSEQ_TW-1:0] postDark_reg;             // Post-dark duration.
    logic [IPSEQ_TW-1:0] fsDelay_reg;              // Frame sync delay.
    logic [IPSEQ_TW-1:0] esDelay_reg;              // Exposure strobe delay.
    logic [IPSEQ_IW-1:0] setLast_reg;              // Last index of the set.
    logic [IPSEQ_TW-1:0] period_reg;               // Frame period of the set.
    logic [IPSEQ_PW-1:0] flash_reg [IPSEQ_DEPTH];  // Pattern store, cleared by reset.
    logic [IPSEQ_PW-1:0] mem_reg   [IPSEQ_DEPTH];  // Internal display memory.
    logic [IPSEQ_DW-1:0] rdata_reg;                // Read data.
    logic                loaded_reg;               // Memory holds a copy.
    ipseq_state_t        state_reg;                // Phase of the pattern.
    logic [IPSEQ_TW-1:0] phase_reg;                // Phase timer.
    logic [IPSEQ_TW-1:0] frame_reg;                // Frame period timer.
    logic [IPSEQ_IW-1:0] idx_reg;                  // Current pattern.
    logic [IPSEQ_TW-1:0] fsCnt_reg;                // Frame sync delay and pulse timer.
    logic                fsArm_reg;                // Frame sync delay running.
    logic                fsOn_reg;                 // Frame sync pulse active.
    logic [IPSEQ_TW-1:0] esCnt_reg;                // Strobe delay timer.
    logic                esOn_reg;                 // Strobe active.
    logic [IPSEQ_PW-1:0] line_reg;                 // Shown pattern line.
    logic                fsOut_reg;                // Frame sync pin.
    logic                esOut_reg;                // Strobe pin.

    // ------------------------------------------------------------------
    // Decode.
    // ------------------------------------------------------------------
    wire enabled   = ctrl_reg[IPSEQ_CTRL_ENABLE];
    wire trigMode  = ctrl_reg[IPSEQ_CTRL_TRIGIN];
    // A start only counts when the same write also selects internal display.
    wire startCmd  = regWrite && regAddr == IPSEQ_REG_CTRL && regWdata[IPSEQ_CTRL_START] &&
                     regWdata[IPSEQ_CTRL_ENABLE];
    wire patWrite  = regWrite && regAddr == IPSEQ_REG_PATWR;
    wire readyNow  = enabled && trigMode && state_reg == IPSEQ_WAIT;
    wire trigTaken = readyNow && link.patternAdvanceIn;
    wire frameEnd  = frame_reg >= period_reg;
    wire freeGo    = enabled && !trigMode && state_reg == IPSEQ_WAIT && (idx_reg != 3'h0 || frameEnd);
    wire patStart  = trigTaken || freeGo;
    wire setStart  = patStart && idx_reg == 3'h0;
    wire phaseDone = phase_reg >= (state_reg == IPSEQ_PRE ? preDark_reg :
                                   state_reg == IPSEQ_EXP ? expose_reg : postDark_reg);
    wire expStart  = state_reg == IPSEQ_PRE && phaseDone;
    wire esRef     = trigMode ? expStart : patStart;
    wire lastPat   = idx_reg == setLast_reg;

    // Register read selection.
    function automatic logic [IPSEQ_DW-1:0] readMux(input logic [3:0] a);
        case (a)
            IPSEQ_REG_CTRL:     readMux = {24'h000000, ctrl_reg};
            IPSEQ_REG_PREDARK:  readMux = {8'h00, preDark_reg};
            IPSEQ_REG_EXPOSE:   readMux = {8'h00, expose_reg};
            IPSEQ_REG_POSTDARK: readMux = {8'h00, postDark_reg};
            IPSEQ_REG_FSDELAY:  readMux = {8'h00, fsDelay_reg};
            IPSEQ_REG_ESDELAY:  readMux = {8'h00, esDelay_reg};
            IPSEQ_REG_SETLEN:   readMux = {5'h00, setLast_reg, period_reg};
            IPSEQ_REG_STATUS:   readMux = {25'h0000000, idx_reg, 1'b0, readyNow, loaded_reg,
                                           state_reg != IPSEQ_IDLE};
            default:            readMux = 32'h00000000;
        endcase
    endfunction

    assign regRdata               = rdata_reg;
    assign link.patternReady      = readyNow;
    assign link.frameSyncOut      = fsOut_reg;
    assign link.exposureStrobeOut = esOut_reg;
    assign mirrorLine             = line_reg;
    assign mirrorColumns          = ctrl_reg[IPSEQ_CTRL_COLREP];
    assign illumOn                = state_reg == IPSEQ_EXP;

    // ------------------------------------------------------------------
    // Command port writes and read data.
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_reg     <= IPSEQ_CTRL_RESET;
            preDark_reg  <= IPSEQ_TIME_RESET;
            expose_reg   <= IPSEQ_TIME_RESET;
            postDark_reg <= IPSEQ_TIME_RESET;
            fsDelay_reg  <= 24'h000000;
            esDelay_reg  <= 24'h000000;
            setLast_reg  <= 3'h0;
            period_reg   <= 24'h000100;
            rdata_reg    <= 32'h00000000;
        end else begin
            rdata_reg <= regRead ? readMux(regAddr) : 32'h00000000;
            if (regWrite) begin
                case (regAddr)
                    IPSEQ_REG_CTRL:     ctrl_reg     <= {3'h0, 1'b0, regWdata[3:0]} |
                                                        {3'h0, regWdata[IPSEQ_CTRL_COLREP], 4'h0};
                    IPSEQ_REG_PREDARK:  preDark_reg  <= regWdata[IPSEQ_TW-1:0];
                    IPSEQ_REG_EXPOSE:   expose_reg   <= regWdata[IPSEQ_TW-1:0];
                    IPSEQ_REG_POSTDARK: postDark_reg <= regWdata[IPSEQ_TW-1:0];
                    IPSEQ_REG_FSDELAY:  fsDelay_reg  <= regWdata[IPSEQ_TW-1:0];
                    IPSEQ_REG_ESDELAY:  esDelay_reg  <= regWdata[IPSEQ_TW-1:0];
                    IPSEQ_REG_SETLEN: begin
                        setLast_reg <= regWdata[26:24];
                        period_reg  <= regWdata[IPSEQ_TW-1:0];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Pattern store and internal memory, one flip-flop row per entry.
    // ------------------------------------------------------------------
    for (genvar i = 0; i < IPSEQ_DEPTH; i++) begin : gMem
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                flash_reg[i] <= 16'h0000;
                mem_reg[i]   <= 16'h0000;
            end else begin
                if (patWrite && regWdata[18:16] == IPSEQ_IW'(i)) begin
                    flash_reg[i] <= regWdata[IPSEQ_PW-1:0];
                end
                if (state_reg == IPSEQ_LOAD && idx_reg == IPSEQ_IW'(i)) begin
                    mem_reg[i] <= flash_reg[i];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Sequencer state machine.
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg  <= IPSEQ_IDLE;
            phase_reg  <= 24'h000000;
            frame_reg  <= 24'h000000;
            idx_reg    <= 3'h0;
            loaded_reg <= 1'b0;
            line_reg   <= 16'h0000;
        end else begin
            frame_reg <= (setStart || frameEnd) ? 24'h000001 : frame_reg + 24'h000001;
            // The enable bit lands in the same cycle as the start, so a start write must not be lost to it.
            if (!enabled && !startCmd) begin
                state_reg <= IPSEQ_IDLE;
                idx_reg   <= 3'h0;
                line_reg  <= 16'h0000;
            end else begin
                case (state_reg)
                    IPSEQ_IDLE: begin
                        if (startCmd) begin
                            state_reg  <= IPSEQ_LOAD;
                            idx_reg    <= 3'h0;
                            loaded_reg <= 1'b0;
                        end
                    end
                    IPSEQ_LOAD: begin
                        idx_reg <= idx_reg + 3'h1;
                        if (idx_reg == 3'h7) begin
                            state_reg  <= IPSEQ_WAIT;
                            loaded_reg <= 1'b1;
                        end
                    end
                    IPSEQ_WAIT: begin
                        if (patStart) begin
                            state_reg <= IPSEQ_PRE;
                            phase_reg <= 24'h000001;
                        end
                    end
                    IPSEQ_PRE: begin
                        phase_reg <= phase_reg + 24'h000001;
                        if (phaseDone) begin
                            state_reg <= IPSEQ_EXP;
                            line_reg  <= mem_reg[idx_reg];
                            phase_reg <= 24'h000001;
                        end
                    end
                    IPSEQ_EXP: begin
                        phase_reg <= phase_reg + 24'h000001;
                        if (phaseDone) begin
                            state_reg <= IPSEQ_POST;
                            line_reg  <= 16'h0000;
                            phase_reg <= 24'h000001;
                        end
                    end
                    IPSEQ_POST: begin
                        phase_reg <= phase_reg + 24'h000001;
                        if (phaseDone) begin
                            state_reg <= IPSEQ_WAIT;
                            idx_reg   <= lastPat ? 3'h0 : idx_reg + 3'h1;
                        end
                    end
                    default: state_reg <= IPSEQ_IDLE;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Frame sync: delay from set start, then a fixed-width pulse.
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fsArm_reg <= 1'b0;
            fsOn_reg  <= 1'b0;
            fsCnt_reg <= 24'h000000;
            fsOut_reg <= 1'b0;
        end else begin
            fsOut_reg <= fsOn_reg ~^ ctrl_reg[IPSEQ_CTRL_FSPOL];
            if (setStart) begin
                fsArm_reg <= 1'b1;
                fsCnt_reg <= 24'h000000;
            end else if (fsArm_reg) begin
                fsCnt_reg <= fsCnt_reg + 24'h000001;
                if (fsCnt_reg >= fsDelay_reg) begin
                    fsArm_reg <= 1'b0;
                    fsOn_reg  <= 1'b1;
                    fsCnt_reg <= 24'h000001;
                end
            end else if (fsOn_reg) begin
                fsCnt_reg <= fsCnt_reg + 24'h000001;
                if (fsCnt_reg >= IPSEQ_FS_PULSE_CYC) begin
                    fsOn_reg <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Exposure strobe: delay from its reference, held through exposure.
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            esCnt_reg <= 24'h000000;
            esOn_reg  <= 1'b0;
            esOut_reg <= 1'b0;
        end else begin
            esOut_reg <= esOn_reg ~^ ctrl_reg[IPSEQ_CTRL_ESPOL];
            if (esRef) begin
                esCnt_reg <= 24'h000001;
            end else if (esCnt_reg != 24'h000000) begin
                esCnt_reg <= esCnt_reg + 24'h000001;
                if (esCnt_reg > esDelay_reg) begin
                    esOn_reg  <= 1'b1;
                    esCnt_reg <= 24'h000000;
                end
            end
            if (state_reg == IPSEQ_EXP && phaseDone) begin
                esOn_reg <= 1'b0;
            end
        end
    end
endmodule

// >>> verilog/ipseq_partner.sv
// Trigger partner end: issues pattern-advance pulses and counts strobes.
module ipseq_partner
    import ipseq_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       resetn,
    // Link.
    ipseq_if.partner        link,
    // User side.
    input  wire logic       fireReq,
    output logic            fireTaken,
    output logic [15:0]     frameCount,
    output logic [15:0]     exposureCount
);
    logic        fsDly_reg;    // Frame sync one cycle ago.
    logic        esDly_reg;    // Exposure strobe one cycle ago.
    logic        trig_reg;     // Trigger output.
    logic [15:0] frames_reg;   // Frame sync rising edges seen.
    logic [15:0] exposures_reg; // Exposure rising edges seen.

    // A trigger is only sent while the device says it is ready.
    wire fireNow = fireReq && link.patternReady && !trig_reg;

    assign link.patternAdvanceIn = trig_reg;
    assign fireTaken     = fireNow;
    assign frameCount    = frames_reg;
    assign exposureCount = exposures_reg;

    // ------------------------------------------------------------------
    // Trigger pulse and edge counters.
    // ------------------------------------------------------------------
    // The counters assume both outputs are programmed active high.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            trig_reg      <= 1'b0;
            fsDly_reg     <= 1'b0;
            esDly_reg     <= 1'b0;
            frames_reg    <= 16'h0000;
            exposures_reg <= 16'h0000;
        end else begin
            trig_reg  <= fireNow;
            fsDly_reg <= link.frameSyncOut;
            esDly_reg <= link.exposureStrobeOut;
            if (link.frameSyncOut && !fsDly_reg) begin
                frames_reg <= frames_reg + 16'h0001;
            end
            if (link.exposureStrobeOut && !esDly_reg) begin
                exposures_reg <= exposures_reg + 16'h0001;
            end
        end
    end
endmodule
